// >>> core/sli_pkg.sv
// constants shared by the line interface core and its line half
// assumes a 50 MHz pclk and an apb master with 32-bit data
package sli_pkg;
  // register byte offsets
  localparam logic [11:0] SLI_OFS_STATUS = 12'h000; // line status read
  localparam logic [11:0] SLI_OFS_CTRL = 12'h004; // control write / readback
  localparam logic [11:0] SLI_OFS_XMIT = 12'h008; // transmit write / readback
  localparam logic [11:0] SLI_OFS_RXSTAT = 12'h00c; // receive half status
  localparam logic [11:0] SLI_OFS_RXCTRL = 12'h010; // receive half control
  localparam logic [11:0] SLI_OFS_RXXMIT = 12'h014; // receive half transmit data
  // control field positions
  localparam int SLI_CTL_XMIT_SEL = 0;
  localparam int SLI_CTL_EXT_CLK = 1;
  localparam int SLI_CTL_REQ_SEND = 2;
  localparam int SLI_CTL_RESYNC = 3;
  localparam int SLI_CTL_TEST_SEL = 4;
  localparam int SLI_CTL_OSC_SEL = 5;
  localparam int SLI_CTL_HIGH_SPEED = 6;
  localparam int SLI_CTL_TEST_DATA = 7;
  localparam int SLI_CTL_SVC_RST = 8;
  localparam int SLI_CTL_OVR_RST = 9;
  localparam int SLI_CTL_W = 10;
  // status field positions
  localparam int SLI_ST_SVC = 0;
  localparam int SLI_ST_RXBUF = 1;
  localparam int SLI_ST_CHANGE = 2;
  localparam int SLI_ST_MODEM = 3;
  localparam int SLI_ST_OVR = 4;
  localparam int SLI_ST_RXLINE = 5;
  localparam int SLI_ST_STROBE_SEL = 6;
  // reset values
  localparam logic [9:0] SLI_CTRL_RST = 10'h000;
  localparam logic SLI_SEND_RST = 1'b1; // idle line is mark
  // backup strobe: no modem clock edge for this long means fall back
  localparam int SLI_BACKUP_NS = 2000;
  localparam int SLI_CLK_NS = 20;
  localparam int SLI_BACKUP_CYC = SLI_BACKUP_NS / SLI_CLK_NS;
  // strobe source codes
  typedef enum logic [1:0] {SLI_SRC_SCAN, SLI_SRC_MODEM, SLI_SRC_OSC, SLI_SRC_BACKUP} sli_src_t;
endpackage

// >>> core/sli_half_if.sv
// signals between the core and one line half
// assumes both ends share pclk
interface sli_half_if;
  logic [9:0] ctrl; // control bits held by the core
  logic send_bit; // pending outgoing bit
  logic svc_clr; // one-cycle acknowledge of the service request
  logic ovr_clr; // overrun reset; one cycle on a control write, held while the overrun reset control bit stays set
  logic svc; // service request flag
  logic ovr; // overrun flag
  logic rx_buf; // receive buffer mark/space
  logic change; // line change
  logic tx_out; // transmit output
  logic [1:0] src; // strobe source in use
  modport half (input ctrl, send_bit, svc_clr, ovr_clr, output svc, ovr, rx_buf, change, tx_out, src);
  modport core (output ctrl, send_bit, svc_clr, ovr_clr, input svc, ovr, rx_buf, change, tx_out, src);
endinterface

// >>> core/sli_half.sv
// one line half: strobe select, service flag, overrun, tx and rx buffers
// assumes line-side inputs are already synchronised and edge-detected
module sli_half (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scan_fall, // internal scan timing pulse fall
  input wire logic modem_fall, // modem clock fall, from clock shift stage
  input wire logic osc_fall, // internal oscillator fall
  input wire logic xclk_fall, // external transmit clock fall
  input wire logic rx_line, // synchronised line data
  sli_half_if.half hb
);
  typedef struct packed
  {
    logic svc;
    logic ovr;
    logic rx_buf;
    logic tx_out;
    logic [6:0] idle_cnt;
  } sli_half_st_t;
  sli_half_st_t s_reg;
  sli_half_st_t s_next;
  logic strobe;
  logic incoming;
  sli_pkg::sli_src_t src;

  ////////////////////////////////////////////////////////////////
  // strobe source and next state
  always_comb
  begin
    s_next = s_reg;
    src = sli_pkg::SLI_SRC_SCAN;
    strobe = 1'b0;
    // source select
    if (hb.ctrl[sli_pkg::SLI_CTL_XMIT_SEL])
    begin
      // (RULE_20) high speed takes tx clock
      if (hb.ctrl[sli_pkg::SLI_CTL_HIGH_SPEED])
      begin
        src = sli_pkg::SLI_SRC_MODEM;
        strobe = xclk_fall;
      end
      // (RULE_10) oscillator or modem clock
      else if (hb.ctrl[sli_pkg::SLI_CTL_EXT_CLK])
      begin
        src = sli_pkg::SLI_SRC_MODEM;
        strobe = modem_fall;
      end
      else
      begin
        src = sli_pkg::SLI_SRC_OSC;
        strobe = osc_fall;
      end
    end
    // (RULE_09) modem clock via shift stage
    else if (hb.ctrl[sli_pkg::SLI_CTL_EXT_CLK])
    begin
      // (RULE_19) backup on missing clock
      if (hb.ctrl[sli_pkg::SLI_CTL_HIGH_SPEED] && s_reg.idle_cnt >= 7'(sli_pkg::SLI_BACKUP_CYC))
      begin
        src = sli_pkg::SLI_SRC_BACKUP;
        strobe = scan_fall;
      end
      else
      begin
        src = sli_pkg::SLI_SRC_MODEM;
        strobe = modem_fall;
      end
    end
    // (RULE_08) receive on scan timing pulse
    else
    begin
      strobe = scan_fall;
    end
    // count cycles since last modem clock edge, saturating
    if (modem_fall)
      s_next.idle_cnt = '0;
    else if (s_reg.idle_cnt < 7'(sli_pkg::SLI_BACKUP_CYC))
      s_next.idle_cnt = s_reg.idle_cnt + 7'd1;
    // (RULE_16) rx or test data
    incoming = hb.ctrl[sli_pkg::SLI_CTL_TEST_SEL] ? hb.ctrl[sli_pkg::SLI_CTL_TEST_DATA] : rx_line;
    // acknowledge clears service request; a strobe in the same cycle wins
    if (hb.svc_clr)
      s_next.svc = 1'b0;
    // (RULE_22) overrun cleared by reset
    if (hb.ovr_clr)
      s_next.ovr = 1'b0;
    if (strobe)
    begin
      // (RULE_13) unserviced request overruns
      if (s_reg.svc && !hb.svc_clr)
        s_next.ovr = 1'b1;
      // (RULE_11) strobe sets request
      s_next.svc = 1'b1;
      // (RULE_15) load outgoing bit
      s_next.tx_out = hb.send_bit;
      // (RULE_18) capture incoming bit
      s_next.rx_buf = incoming;
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg.svc <= 1'b0;
      s_reg.ovr <= 1'b0;
      s_reg.rx_buf <= sli_pkg::SLI_SEND_RST;
      s_reg.tx_out <= sli_pkg::SLI_SEND_RST;
      s_reg.idle_cnt <= '0;
    end
    else
      s_reg <= s_next;
  end

  // outputs
  assign hb.svc = s_reg.svc;
  assign hb.ovr = s_reg.ovr;
  assign hb.rx_buf = s_reg.rx_buf;
  assign hb.tx_out = s_reg.tx_out;
  assign hb.src = src;
  // (RULE_17) compare incoming with buffer
  assign hb.change = (incoming != s_reg.rx_buf);

  ////////////////////////////////////////////////////////////////
  // checks
  // (RULE_13) overrun check
  property p_ovr_set; // RULE_13
    @(posedge pclk) disable iff (!presetn)
      (strobe && s_reg.svc && !hb.svc_clr) |=> s_reg.ovr;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not set");
  property p_svc_set; // RULE_11
    @(posedge pclk) disable iff (!presetn)
      strobe |=> s_reg.svc;
  endproperty
  a_svc_set: assert property (p_svc_set) else $error("service request not set");
  property p_tx_load; // RULE_15
    @(posedge pclk) disable iff (!presetn)
      strobe |=> (s_reg.tx_out == $past(hb.send_bit));
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx bit not loaded");
  property p_rx_cap; // RULE_18
    @(posedge pclk) disable iff (!presetn)
      strobe |=> (s_reg.rx_buf == $past(incoming));
  endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("rx bit not captured");
  property p_rx_hold; // RULE_18
    @(posedge pclk) disable iff (!presetn)
      !strobe |=> $stable(s_reg.rx_buf);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx buffer moved without strobe");
  property p_ovr_clr; // RULE_22
    @(posedge pclk) disable iff (!presetn)
      (hb.ovr_clr && !(strobe && s_reg.svc && !hb.svc_clr)) |=> !s_reg.ovr;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");
  property p_ovr_sticky; // RULE_22
    @(posedge pclk) disable iff (!presetn)
      (s_reg.ovr && !hb.ovr_clr) |=> s_reg.ovr;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun dropped");
  property p_rcv_src; // RULE_08
    @(posedge pclk) disable iff (!presetn)
      (!hb.ctrl[sli_pkg::SLI_CTL_XMIT_SEL] && !hb.ctrl[sli_pkg::SLI_CTL_EXT_CLK]) |-> (strobe == scan_fall);
  endproperty
  a_rcv_src: assert property (p_rcv_src) else $error("receive strobe source wrong");
  property p_hs_tx; // RULE_20
    @(posedge pclk) disable iff (!presetn)
      (hb.ctrl[sli_pkg::SLI_CTL_XMIT_SEL] && hb.ctrl[sli_pkg::SLI_CTL_HIGH_SPEED]) |-> (strobe == xclk_fall);
  endproperty
  a_hs_tx: assert property (p_hs_tx) else $error("high speed tx strobe wrong");
endmodule

// >>> core/sli_core.sv
// What this block does
// (RULE_01) transmit half low address, receive high
// (RULE_02) two independent identical line halves
// (RULE_03) status read: modem, buffer, service flag
// (RULE_04) scanner writes control over control write
// (RULE_05) control readback returns last control write
// (RULE_06) transmit write stores next outgoing bit
// (RULE_07) transmit readback adds overrun, line level
// (RULE_08) neither select: scan pulse strobe
// (RULE_09) external clock: modem clock via shift
// (RULE_10) transmit: oscillator or modem clock
// (RULE_11) strobe falling edge sets service request
// (RULE_12) scanner clears request before next strobe
// (RULE_13) unserviced request at strobe sets overrun
// (RULE_14) scanner sets modes after service request
// (RULE_15) strobe loads outgoing bit, drives line
// (RULE_16) receive picks line or test data
// (RULE_17) line change when incoming differs buffer
// (RULE_18) strobe falling edge captures incoming bit
// (RULE_19) high speed receive falls back scan pulse
// (RULE_20) high speed transmit uses transmit clock
// (RULE_21) type two scanner ignores, holds overrun reset
// (RULE_22) overrun stays until overrun reset
//
// apb slave holding two line halves; line pins pass three flip-flops
// assumes an apb master on pclk with 32-bit data
//
// Decided for this implementation: the register offsets and register access over APB.
module sli_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scan_pulse, // internal scan timing pulse
  input wire logic osc_clk, // internal transmit oscillator
  input wire logic modem_tx_clk, // modem transmit clock pin
  input wire logic modem_rx_clk, // modem receive clock pin
  input wire logic ext_tx_clk, // high speed external transmit clock
  input wire logic rx_data_pin, // line receive data
  input wire logic modem_status, // modem ready status
  output logic tx_data_pin, // line transmit data
  output logic req_send // request to send to the modem
);
  // synchroniser stages: 3 per pin, 7 pins
  typedef struct packed
  {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] lvl;
    logic [9:0] tx_ctrl;
    logic [9:0] rx_ctrl;
    logic tx_send;
    logic rx_send;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic tx_out;
    logic rts;
    logic [1:0] tx_pulse;
    logic [1:0] rx_pulse;
  } sli_core_st_t;
  sli_core_st_t s_reg;
  sli_core_st_t s_next;
  sli_half_if tx_hb ();
  sli_half_if rx_hb ();
  logic [6:0] fall;
  logic setup_wr;
  logic setup;

  // status word for one half
  function automatic logic [31:0] sli_status(input logic svc, input logic rxb, input logic chg,
      input logic mdm, input logic [1:0] src);
    logic [31:0] w;
    w = '0;
    w[sli_pkg::SLI_ST_SVC] = svc;
    w[sli_pkg::SLI_ST_RXBUF] = rxb;
    w[sli_pkg::SLI_ST_CHANGE] = chg;
    w[sli_pkg::SLI_ST_MODEM] = mdm;
    w[sli_pkg::SLI_ST_STROBE_SEL +: 2] = src;
    return w;
  endfunction

  // transmit readback word for one half
  function automatic logic [31:0] sli_xmit(input logic snd, input logic ovr, input logic line);
    logic [31:0] w;
    w = '0;
    w[0] = snd;
    w[sli_pkg::SLI_ST_OVR] = ovr;
    w[sli_pkg::SLI_ST_RXLINE] = line;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////
  // bus decode and synchronisers
  always_comb
  begin
    s_next = s_reg;
    setup = psel && !penable;
    // writes land only at the edge where the master sees pready high
    setup_wr = psel && penable && pwrite && s_reg.ready;
    // a pin change counts once stages two and three agree
    s_next.s1 = {scan_pulse, osc_clk, modem_tx_clk, modem_rx_clk, ext_tx_clk, rx_data_pin, modem_status};
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    for (int i = 0; i < 7; i++)
      if (s_reg.s2[i] == s_reg.s3[i])
        s_next.lvl[i] = s_reg.s3[i];
    fall = s_reg.lvl & ~s_next.lvl;
    // acknowledge pulses last one cycle
    s_next.tx_pulse = '0;
    s_next.rx_pulse = '0;
    // answers are registered: ready in the access cycle
    s_next.ready = setup;
    s_next.err = 1'b0;
    s_next.rdata = '0;
    if (setup)
    begin
      unique case (paddr)
        // (RULE_03) status read
        sli_pkg::SLI_OFS_STATUS:
          s_next.rdata = sli_status(tx_hb.svc, tx_hb.rx_buf, tx_hb.change, s_reg.lvl[0], tx_hb.src);
        sli_pkg::SLI_OFS_RXSTAT:
          s_next.rdata = sli_status(rx_hb.svc, rx_hb.rx_buf, rx_hb.change, s_reg.lvl[0], rx_hb.src);
        // (RULE_05) control readback
        sli_pkg::SLI_OFS_CTRL:
          s_next.rdata = {22'h0, s_reg.tx_ctrl};
        sli_pkg::SLI_OFS_RXCTRL:
          s_next.rdata = {22'h0, s_reg.rx_ctrl};
        // (RULE_07) transmit readback
        sli_pkg::SLI_OFS_XMIT:
          s_next.rdata = sli_xmit(s_reg.tx_send, tx_hb.ovr, s_reg.lvl[1]);
        sli_pkg::SLI_OFS_RXXMIT:
          s_next.rdata = sli_xmit(s_reg.rx_send, rx_hb.ovr, s_reg.lvl[1]);
        default:
          s_next.err = 1'b1;
      endcase
    end
    if (setup_wr)
    begin
      // (RULE_04) control write, reset bits pulse
      if (paddr == sli_pkg::SLI_OFS_CTRL)
      begin
        s_next.tx_ctrl = pwdata[9:0];
        s_next.tx_pulse = pwdata[sli_pkg::SLI_CTL_OVR_RST:sli_pkg::SLI_CTL_SVC_RST];
      end
      if (paddr == sli_pkg::SLI_OFS_RXCTRL)
      begin
        s_next.rx_ctrl = pwdata[9:0];
        s_next.rx_pulse = pwdata[sli_pkg::SLI_CTL_OVR_RST:sli_pkg::SLI_CTL_SVC_RST];
      end
      // (RULE_06) transmit write stores bit
      if (paddr == sli_pkg::SLI_OFS_XMIT)
        s_next.tx_send = pwdata[0];
      if (paddr == sli_pkg::SLI_OFS_RXXMIT)
        s_next.rx_send = pwdata[0];
    end
    // (RULE_21) held overrun reset clears any overrun one cycle after a strobe sets it
    if (s_reg.tx_ctrl[sli_pkg::SLI_CTL_OVR_RST])
      s_next.tx_pulse[1] = 1'b1;
    if (s_reg.rx_ctrl[sli_pkg::SLI_CTL_OVR_RST])
      s_next.rx_pulse[1] = 1'b1;
    // (RULE_15) line driven from transmit half
    s_next.tx_out = tx_hb.tx_out;
    s_next.rts = s_reg.tx_ctrl[sli_pkg::SLI_CTL_REQ_SEND];
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.tx_ctrl <= sli_pkg::SLI_CTRL_RST;
      s_reg.rx_ctrl <= sli_pkg::SLI_CTRL_RST;
      s_reg.tx_send <= sli_pkg::SLI_SEND_RST;
      s_reg.rx_send <= sli_pkg::SLI_SEND_RST;
      s_reg.tx_out <= sli_pkg::SLI_SEND_RST;
    end
    else
      s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////
  // half wiring; lvl bits: 6 scan,5 osc,4 mtx,3 mrx,2 xclk,1 rxd,0 status
  assign tx_hb.ctrl = s_reg.tx_ctrl;
  assign tx_hb.send_bit = s_reg.tx_send;
  assign tx_hb.svc_clr = s_reg.tx_pulse[0];
  assign tx_hb.ovr_clr = s_reg.tx_pulse[1];
  assign rx_hb.ctrl = s_reg.rx_ctrl;
  assign rx_hb.send_bit = s_reg.rx_send;
  assign rx_hb.svc_clr = s_reg.rx_pulse[0];
  assign rx_hb.ovr_clr = s_reg.rx_pulse[1];

  // (RULE_02) two independent halves
  sli_half u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .scan_fall(fall[6]),
    .modem_fall(fall[4]),
    .osc_fall(fall[5]),
    .xclk_fall(fall[2]),
    .rx_line(s_reg.lvl[1]),
    .hb(tx_hb)
  );
  sli_half u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .scan_fall(fall[6]),
    .modem_fall(fall[3]),
    .osc_fall(fall[5]),
    .xclk_fall(fall[2]),
    .rx_line(s_reg.lvl[1]),
    .hb(rx_hb)
  );

  // outputs straight from flip-flops
  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;
  assign tx_data_pin = s_reg.tx_out;
  assign req_send = s_reg.rts;

  ////////////////////////////////////////////////////////////////
  // bus checks
  property p_ctrl_rb; // RULE_05
    @(posedge pclk) disable iff (!presetn)
      (setup_wr && paddr == sli_pkg::SLI_OFS_CTRL) |=> (s_reg.tx_ctrl == $past(pwdata[9:0]));
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback mismatch");
endmodule

// >>> bench/sli_modem_model.sv
// behavioural synchronous modem on the far side of the line interface
// assumes the bench gates it with go; clocks idle high between frames
module sli_modem_model (
  input wire logic go, // frame runs while high
  input wire logic [7:0] pattern, // receive bits, bit 0 first
  input wire logic tx_data_pin, // line transmit data from the block
  input wire logic req_send, // request to send from the block
  output logic modem_tx_clk, // transmit clock, 160 ns period
  output logic modem_rx_clk, // receive clock, same phase
  output logic rx_data_pin, // receive data to the block
  output logic modem_status, // ready, follows request to send
  output logic [7:0] tx_seen // transmit bits sampled, newest in bit 0
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx; // next receive bit

  ////////////////////////////////////////////////////////////////
  // modem reports ready as soon as the block asks to send
  assign modem_status = req_send;

  // clock stands still outside frames; 3 ns offset keeps it off pclk edges
  initial
  begin
    modem_tx_clk = 1'b1;
    modem_rx_clk = 1'b1;
    rx_data_pin = 1'b1;
    tx_seen = 8'h00;
    forever
    begin
      wait (go);
      #3;
      idx = 1;
      rx_data_pin = pattern[0];
      while (go)
      begin
        #80;
        modem_tx_clk = 1'b0;
        modem_rx_clk = 1'b0;
        // previous strobe's bit has been on the pin for 63 ns of the 160 ns cell
        tx_seen = {tx_seen[6:0], tx_data_pin};
        #80;
        modem_tx_clk = 1'b1;
        modem_rx_clk = 1'b1;
        rx_data_pin = pattern[idx[2:0]];
        idx++;
      end
      // released line shows the inverse, never the held value
      rx_data_pin = ~rx_data_pin;
    end
  end
endmodule

// >>> bench/tb_top.sv
// self-checking bench: apb scanner tasks plus a modem model
// assumes sli_core answers every apb access after one setup cycle
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_ST = sli_pkg::SLI_OFS_STATUS; // transmit half, low pair address
  localparam logic [11:0] A_CT = sli_pkg::SLI_OFS_CTRL;
  localparam logic [11:0] A_XM = sli_pkg::SLI_OFS_XMIT;
  localparam logic [11:0] A_RS = sli_pkg::SLI_OFS_RXSTAT; // receive half, high pair address
  localparam logic [11:0] A_RC = sli_pkg::SLI_OFS_RXCTRL;
  localparam logic [31:0] C_XS = 32'h001, C_EC = 32'h002, C_RS = 32'h004, C_TS = 32'h010;
  localparam logic [31:0] C_OS = 32'h020, C_HS = 32'h040, C_TD = 32'h080, C_SR = 32'h100, C_OR = 32'h200;
  localparam logic [31:0] SRC_CFG [4] = '{32'h000, 32'h002, 32'h021, 32'h003};
  localparam logic [31:0] SRC_EXP [4] = '{32'h000, 32'h040, 32'h080, 32'h040};
  localparam int SRC_PIN [4] = '{0, 1, 2, 1};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_val;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic scan_pulse, osc_clk, ext_tx_clk, go, mtx, mrx, rxd, mstat, txd, rts;
  logic [7:0] pattern, tx_seen;
  int bad_count, samples_checked, cyc;

  ////////////////////////////////////////////////////////////////
  sli_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_pulse(scan_pulse), .osc_clk(osc_clk), .modem_tx_clk(mtx), .modem_rx_clk(mrx),
    .ext_tx_clk(ext_tx_clk), .rx_data_pin(rxd), .modem_status(mstat), .tx_data_pin(txd), .req_send(rts));
  sli_modem_model modem_u (.go(go), .pattern(pattern), .tx_data_pin(txd), .req_send(rts),
    .modem_tx_clk(mtx), .modem_rx_clk(mrx), .rx_data_pin(rxd), .modem_status(mstat), .tx_seen(tx_seen));

  // free-running pclk, 20 ns
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // watchdog: the whole run needs a few hundred cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // sample pready at each rising edge; take data and release there
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_val = prdata;
    err_val = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(e, rd_val & m, n);
  endtask

  // one frame of n modem clock falls
  task automatic run_bits(input int n);
    @(posedge pclk);
    go <= 1'b1;
    repeat (8 * n - 2) @(posedge pclk);
    go <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask

  // one falling edge on a strobe source: 0 scan, 1 modem, 2 osc, 3 ext tx clock
  task automatic strobe(input int k);
    if (k == 1)
      run_bits(1);
    else
    begin
      @(posedge pclk);
      if (k == 0) scan_pulse <= 1'b0;
      else if (k == 2) osc_clk <= 1'b0;
      else ext_tx_clk <= 1'b0;
      repeat (6) @(posedge pclk);
      scan_pulse <= 1'b1;
      osc_clk <= 1'b1;
      ext_tx_clk <= 1'b1;
      repeat (8) @(posedge pclk);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(A_CT, 32'h3ff, 32'h0, "ctrl reset");
    rdchk(A_RC, 32'h3ff, 32'h0, "rx ctrl reset");
    rdchk(A_XM, 32'h1, 32'h1, "send reset");
    chk(32'h1, {31'h0, txd}, "tx pin idle");
    apb(1'b0, 12'h018, 32'h0);
    chk(32'h1, {31'h0, err_val}, "unmapped err");
    chk(32'h0, rd_val, "unmapped data");
  endtask

  task automatic t_ctrl();
    apb(1'b1, A_CT, C_RS | C_OS | C_TD);
    apb(1'b1, A_RC, C_TS | C_HS);
    rdchk(A_CT, 32'hff, 32'ha4, "ctrl readback");
    rdchk(A_RC, 32'hff, 32'h50, "rx ctrl readback");
    chk(32'h1, {31'h0, rts}, "req send pin");
    rdchk(A_ST, 32'h8, 32'h8, "modem status");
    apb(1'b1, A_RC, 32'h0);
  endtask

  task automatic t_scan();
    apb(1'b1, A_CT, C_TS | C_TD | C_SR | C_OR);
    apb(1'b1, A_XM, 32'h0);
    rdchk(A_XM, 32'h1, 32'h0, "send readback");
    apb(1'b1, A_CT, C_TS | C_TD);
    strobe(0);
    rdchk(A_ST, 32'hc7, 32'h03, "scan strobe status");
    chk(32'h0, {31'h0, txd}, "tx pin loaded");
    apb(1'b1, A_CT, C_TS);
    rdchk(A_ST, 32'h4, 32'h4, "line change set");
    strobe(0);
    rdchk(A_XM, 32'h10, 32'h10, "overrun set");
    rdchk(A_ST, 32'h6, 32'h0, "line change clear");
    apb(1'b1, A_CT, C_TS | C_OR);
    rdchk(A_XM, 32'h10, 32'h0, "overrun cleared");
    apb(1'b1, A_CT, C_TS | C_SR);
    rdchk(A_ST, 32'h1, 32'h0, "service cleared");
    rdchk(A_XM, 32'h20, {26'h0, rxd, 5'h0}, "rx line level");
  endtask

  task automatic t_sources();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, A_CT, SRC_CFG[i] | C_SR);
      rdchk(A_ST, 32'hc1, SRC_EXP[i], "strobe source");
      strobe(SRC_PIN[i]);
      rdchk(A_ST, 32'h1, 32'h1, "service from source");
    end
  endtask

  task automatic t_modem();
    apb(1'b1, A_CT, C_XS | C_EC | C_SR);
    apb(1'b1, A_XM, 32'h1);
    apb(1'b1, A_RC, C_EC);
    pattern <= 8'h03;
    run_bits(3);
    chk(32'h3, {29'h0, tx_seen[2:0]}, "tx bits on wire");
    rdchk(A_RS, 32'hc6, 32'h44, "rx capture");
    rdchk(A_XM, 32'h10, 32'h10, "modem overrun");
  endtask

  task automatic t_backup();
    apb(1'b1, A_RC, C_HS | C_EC);
    repeat (110) @(posedge pclk);
    rdchk(A_RS, 32'hc0, 32'hc0, "backup source");
    apb(1'b1, A_CT, C_XS | C_HS | C_OR | C_SR);
    strobe(3);
    strobe(3);
    rdchk(A_ST, 32'h1, 32'h1, "ext tx clock service");
    rdchk(A_XM, 32'h10, 32'h0, "overrun held off");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence; all line sources idle high
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, go} = '0;
    {scan_pulse, osc_clk, ext_tx_clk} = 3'b111;
    pattern = 8'h00;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_scan();
    t_sources();
    t_modem();
    t_backup();
    report_and_stop();
  end
endmodule
